// >>> src/chgrb_pkg.sv
// Package: constants and types for the charger register bank.
// Assumes one 10 MHz core clock and an external SMBus engine.
package chgrb_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_OFS  = 8'h12;
    localparam logic [7:0] COND_FLAGS_OFS = 8'h13;
    localparam logic [7:0] CHG_CUR_OFS    = 8'h14;
    localparam logic [7:0] CHG_VOLT_OFS   = 8'h15;
    localparam logic [7:0] IN_LIMIT_OFS   = 8'h3F;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CUR_LSB          = 7;
    localparam int CUR_MSB          = 13;
    localparam logic [15:0] CUR_MASK      = 16'h3F80;
    localparam logic [15:0] VOLT_MASK     = 16'h7FFE;
    localparam logic [15:0] CTRL_MASK     = 16'h0FFD;
    localparam logic [15:0] CTRL_RESET    = 16'h0001;
    localparam logic [15:0] SETPT_RESET   = 16'h0000;
    localparam logic [15:0] FLAGS_RESET   = 16'h0007;
    localparam int CTL_INHIBIT     = 0;
    localparam int CTL_SOFT_RESET  = 2;
    localparam int CTL_MON_SEL     = 3;
    localparam int CTL_LEARN       = 4;
    localparam int CTL_FREQ_SEL    = 5;
    localparam int CTL_OC_EN       = 6;
    localparam int CTL_OC_RATIO_LO = 7;
    localparam int CTL_DEPL_LO     = 9;

    // ------------------------------------------------------------
    // Voltage decode constants (millivolts, field bits only)
    // ------------------------------------------------------------
    localparam logic [15:0] MV_WAKE   = 16'h2328;
    localparam logic [15:0] MV_3C_LO  = 16'h2EE0;
    localparam logic [15:0] MV_3C_HI  = 16'h3840;
    localparam logic [15:0] MV_4C_LO  = 16'h3E80;
    localparam logic [15:0] MV_4C_HI  = 16'h4B00;
    localparam logic [6:0]  CODE_MAX  = 7'h7F;
    // Step sizes in micro-volts: 18750 and 25000
    localparam logic [31:0] UV_STEP_3C = 32'h0000_493E;
    localparam logic [31:0] UV_STEP_4C = 32'h0000_61A8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 10_000_000;
    localparam int DEGLITCH_MS   = 8;
    localparam int DEGLITCH_CYC  = CLK_HZ / 1000 * DEGLITCH_MS;

    // Voltage target as handed to the regulation loop
    typedef struct packed {
        logic       wake_9v;
        logic       four_cell;
        logic [6:0] offset;
    } chgrb_vtarget_t;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b01,
        BUS_RDACK = 2'b10
    } chgrb_bus_state_t;

endpackage

// >>> src/chgrb_bank.sv
// Register bank for a multi-cell charger, reached by an SMBus engine.
// Assumes the engine presents decoded word writes and reads as one-cycle strobes.
`timescale 1ns/1ns
module chgrb_bank (
    input  wire logic        CORE_CLK_I,
    input  wire logic        RST_I,
    input  wire logic        WR_STB_I,
    input  wire logic        RD_STB_I,
    input  wire logic [7:0]  CMD_I,
    input  wire logic [15:0] WDATA_I,
    output logic      [15:0] RDATA_O,
    output logic             RVALID_O,
    input  wire logic        CHARGE_ENABLE_PIN_N_I,
    input  wire logic        ADAPTER_PRESENT_I,
    input  wire logic        RAIL_READY_I,
    input  wire logic        VLOOP_ACTIVE_I,
    input  wire logic        BAT_DEPLETED_I,
    output logic             ALERT_O,
    output logic             ALERT_OE_O,
    output logic             CHARGER_ON_O,
    output logic      [6:0]  CHARGE_CURRENT_CODE_O,
    output logic      [6:0]  INPUT_LIMIT_CODE_O,
    output logic      [8:0]  VOLTAGE_TARGET_O,
    output logic             MONITOR_SELECT_O,
    output logic             BATTERY_TO_SYSTEM_O,
    output logic             FREQ_500K_O,
    output logic             OC_PROTECT_O,
    output logic      [1:0]  OC_RATIO_O,
    output logic      [2:0]  DEPLETED_SELECT_O
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
        end else begin
            sync1_reg <= {CHARGE_ENABLE_PIN_N_I, ADAPTER_PRESENT_I, RAIL_READY_I,
                          VLOOP_ACTIVE_I, BAT_DEPLETED_I};
            sync2_reg <= sync1_reg;
        end
    end
    logic pin_inhibit;
    logic adapter_s;
    logic rail_s;
    logic vloop_s;
    logic depl_s;
    assign {pin_inhibit, adapter_s, rail_s, vloop_s, depl_s} = sync2_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] cur_reg;
    logic [15:0] volt_reg;
    logic [15:0] inlim_reg;
    logic        soft_rst;
    assign soft_rst = WR_STB_I && CMD_I == chgrb_pkg::MODE_CTRL_OFS
                      && WDATA_I[chgrb_pkg::CTL_SOFT_RESET];

    // ------------------------------------------------------------
    // Current word clamp
    // ------------------------------------------------------------
    // Words past the ceiling clamp to full scale rather than wrap to zero,
    // so an oversized request never silently turns the charger off
    function automatic logic [15:0] cur_word(input logic [15:0] w);
        if (w[15:14] != 2'b00) begin
            cur_word = chgrb_pkg::CUR_MASK;
        end else begin
            cur_word = w & chgrb_pkg::CUR_MASK;
        end
    endfunction

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ctrl_reg  <= chgrb_pkg::CTRL_RESET;
            cur_reg   <= chgrb_pkg::SETPT_RESET;
            volt_reg  <= chgrb_pkg::SETPT_RESET;
            inlim_reg <= chgrb_pkg::SETPT_RESET;
        end else if (soft_rst) begin
            // Self-clearing reset: disabled, 300 kHz, zero setpoints
            ctrl_reg  <= chgrb_pkg::CTRL_RESET;
            cur_reg   <= chgrb_pkg::SETPT_RESET;
            volt_reg  <= chgrb_pkg::SETPT_RESET;
            inlim_reg <= chgrb_pkg::SETPT_RESET;
        end else if (WR_STB_I) begin
            case (CMD_I)
                // Unused bits 1, 12..15 never stored
                chgrb_pkg::MODE_CTRL_OFS: ctrl_reg  <= WDATA_I & chgrb_pkg::CTRL_MASK;
                chgrb_pkg::CHG_CUR_OFS:   cur_reg   <= cur_word(WDATA_I);
                chgrb_pkg::IN_LIMIT_OFS:  inlim_reg <= cur_word(WDATA_I);
                chgrb_pkg::CHG_VOLT_OFS:  volt_reg  <= WDATA_I & chgrb_pkg::VOLT_MASK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Voltage decode
    // ------------------------------------------------------------
    // Truncating divide; constant divisors keep this a plain multiplier net
    function automatic logic [6:0] volt_code(input logic [15:0] mv,
                                             input logic [15:0] base,
                                             input logic [31:0] step_uv);
        logic [31:0] q;
        q = ({16'h0000, mv - base} * 32'd1000) / step_uv;
        volt_code = (q > 32'd127) ? chgrb_pkg::CODE_MAX : q[6:0];
    endfunction

    chgrb_pkg::chgrb_vtarget_t vt;
    logic                      volt_bad;
    always_comb begin
        vt       = '0;
        volt_bad = 1'b0;
        if (volt_reg == chgrb_pkg::MV_WAKE) begin
            vt.wake_9v = 1'b1;
        end else if (volt_reg > chgrb_pkg::MV_4C_HI) begin
            vt.four_cell = 1'b1;
            vt.offset    = chgrb_pkg::CODE_MAX;
        end else if (volt_reg >= chgrb_pkg::MV_4C_LO) begin
            vt.four_cell = 1'b1;
            vt.offset    = volt_code(volt_reg, chgrb_pkg::MV_4C_LO,
                                     chgrb_pkg::UV_STEP_4C);
        end else if (volt_reg >= chgrb_pkg::MV_3C_LO
                     && volt_reg <= chgrb_pkg::MV_3C_HI) begin
            vt.offset = volt_code(volt_reg, chgrb_pkg::MV_3C_LO,
                                  chgrb_pkg::UV_STEP_3C);
        end else begin
            volt_bad = 1'b1;
        end
    end

    // Clamped words stay on; only a stored zero disables
    logic cur_zero;
    logic lim_zero;
    logic run;
    assign cur_zero = cur_reg == 16'h0000;
    assign lim_zero = inlim_reg == 16'h0000;
    assign run = !ctrl_reg[chgrb_pkg::CTL_INHIBIT] && !pin_inhibit
                 && !cur_zero && !lim_zero && !volt_bad;

    // ------------------------------------------------------------
    // Deglitch on synchronised adapter and depleted inputs
    // ------------------------------------------------------------
    logic [1:0]  dg_reg;
    logic [17:0] dg_cnt_reg;
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dg_reg     <= 2'b00;
            dg_cnt_reg <= 18'h00000;
        end else if ({adapter_s, depl_s} == dg_reg) begin
            dg_cnt_reg <= 18'h00000;
        end else if (dg_cnt_reg == 18'(chgrb_pkg::DEGLITCH_CYC - 1)) begin
            dg_reg     <= {adapter_s, depl_s};
            dg_cnt_reg <= 18'h00000;
        end else begin
            dg_cnt_reg <= dg_cnt_reg + 18'h00001;
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic        learn_eff;
    assign learn_eff = ctrl_reg[chgrb_pkg::CTL_LEARN] && !dg_reg[0];
    always_comb begin
        flags_next     = 16'h0000;
        flags_next[0]  = !(dg_reg[1] && rail_s);
        flags_next[1]  = !run;
        flags_next[2]  = !(run && vloop_s);
        flags_next[6]  = learn_eff || !dg_reg[1];
        flags_next[7]  = dg_reg[1] && !learn_eff;
        flags_next[11] = dg_reg[0];
        flags_next[12] = volt_bad;
    end

    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            flags_reg <= chgrb_pkg::FLAGS_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // Alert: change wins over the clearing read
    // ------------------------------------------------------------
    logic status_rd;
    assign status_rd = RD_STB_I && CMD_I == chgrb_pkg::COND_FLAGS_OFS;
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ALERT_OE_O <= 1'b0;
        end else if (flags_next != flags_reg) begin
            ALERT_OE_O <= 1'b1;
        end else if (status_rd) begin
            ALERT_OE_O <= 1'b0;
        end
    end
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ALERT_O <= 1'b0;
        end else begin
            ALERT_O <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port; control word reads as zero
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            RDATA_O  <= 16'h0000;
            RVALID_O <= 1'b0;
        end else begin
            RVALID_O <= RD_STB_I;
            if (RD_STB_I) begin
                case (CMD_I)
                    chgrb_pkg::COND_FLAGS_OFS: RDATA_O <= flags_reg;
                    chgrb_pkg::CHG_CUR_OFS:    RDATA_O <= cur_reg;
                    chgrb_pkg::CHG_VOLT_OFS:   RDATA_O <= volt_reg;
                    chgrb_pkg::IN_LIMIT_OFS:   RDATA_O <= inlim_reg;
                    default:                   RDATA_O <= 16'h0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Analog-side controls
    // ------------------------------------------------------------
    // Enable and current codes to the regulation loop
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            CHARGER_ON_O          <= 1'b0;
            CHARGE_CURRENT_CODE_O <= 7'h00;
            INPUT_LIMIT_CODE_O    <= 7'h00;
        end else begin
            CHARGER_ON_O          <= run;
            CHARGE_CURRENT_CODE_O <= cur_reg[chgrb_pkg::CUR_MSB:chgrb_pkg::CUR_LSB];
            INPUT_LIMIT_CODE_O    <= inlim_reg[chgrb_pkg::CUR_MSB:chgrb_pkg::CUR_LSB];
        end
    end

    // Voltage target; registered so the loop never sees decode glitches
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            VOLTAGE_TARGET_O      <= 9'h000;
        end else begin
            VOLTAGE_TARGET_O      <= vt;
        end
    end

    // Mode controls from the control word; battery-to-system from status bit 6
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            MONITOR_SELECT_O      <= 1'b0;
            BATTERY_TO_SYSTEM_O   <= 1'b0;
            FREQ_500K_O           <= 1'b0;
            OC_PROTECT_O          <= 1'b0;
            OC_RATIO_O            <= 2'h0;
            DEPLETED_SELECT_O     <= 3'h0;
        end else begin
            MONITOR_SELECT_O      <= ctrl_reg[chgrb_pkg::CTL_MON_SEL];
            BATTERY_TO_SYSTEM_O   <= flags_reg[6];
            FREQ_500K_O           <= ctrl_reg[chgrb_pkg::CTL_FREQ_SEL];
            OC_PROTECT_O          <= ctrl_reg[chgrb_pkg::CTL_OC_EN];
            OC_RATIO_O            <= ctrl_reg[chgrb_pkg::CTL_OC_EN]
                                     ? ctrl_reg[chgrb_pkg::CTL_OC_RATIO_LO +: 2]
                                     : 2'h0;
            DEPLETED_SELECT_O     <= ctrl_reg[chgrb_pkg::CTL_DEPL_LO +: 3];
        end
    end

endmodule

// >>> test/chgrb_bank_properties.sv
// Checker: timing relations on the register bank ports.
// Assumes one clock domain and the active-high asynchronous reset.
`timescale 1ns/1ns
module chgrb_bank_checker (
    input wire logic        CORE_CLK_I,
    input wire logic        RST_I,
    input wire logic        WR_STB_I,
    input wire logic        RD_STB_I,
    input wire logic [7:0]  CMD_I,
    input wire logic [15:0] WDATA_I,
    input wire logic [15:0] RDATA_O,
    input wire logic        RVALID_O,
    input wire logic        CHARGE_ENABLE_PIN_N_I,
    input wire logic        ALERT_O,
    input wire logic        ALERT_OE_O,
    input wire logic        CHARGER_ON_O,
    input wire logic [6:0]  CHARGE_CURRENT_CODE_O,
    input wire logic [6:0]  INPUT_LIMIT_CODE_O,
    input wire logic [8:0]  VOLTAGE_TARGET_O,
    input wire logic        BATTERY_TO_SYSTEM_O,
    input wire logic        OC_PROTECT_O,
    input wire logic [1:0]  OC_RATIO_O
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    a_alert_data_low: assert property (ALERT_O == 1'b0)
        else $error("alert data not low");
    a_alert_holds: assert property (ALERT_OE_O && !(RD_STB_I && CMD_I == 8'h13) |=> ALERT_OE_O)
        else $error("alert released without status read");
    a_ctrl_write_only: assert property (RD_STB_I && CMD_I == 8'h12 |=> RVALID_O && RDATA_O == 16'h0000)
        else $error("control read not zero");
    a_ratio_gated: assert property (!OC_PROTECT_O |-> OC_RATIO_O == 2'b00)
        else $error("ratio active with protection off");
    a_pin_disables: assert property (CHARGE_ENABLE_PIN_N_I [*6] |-> !CHARGER_ON_O)
        else $error("charger on with pin high");
    a_wake_target: assert property (VOLTAGE_TARGET_O[8] |-> VOLTAGE_TARGET_O[7:0] == 8'h00)
        else $error("wake target mixed with offset");
    a_batt_status: assert property (RVALID_O && $past(CMD_I) == 8'h13 |-> RDATA_O[6] == BATTERY_TO_SYSTEM_O)
        else $error("battery status bit differs from output");
    a_loop_needs_on: assert property (RVALID_O && $past(CMD_I) == 8'h13 && !RDATA_O[2] |-> !RDATA_O[1])
        else $error("voltage loop active while charger off");
    a_soft_reset: assert property (WR_STB_I && CMD_I == 8'h12 && WDATA_I[2] |=> ##[1:3]
        (CHARGE_CURRENT_CODE_O == 7'h00 && INPUT_LIMIT_CODE_O == 7'h00 && !CHARGER_ON_O))
        else $error("soft reset left setpoints");
endmodule
bind chgrb_bank chgrb_bank_checker u_chk (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
    .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .CMD_I(CMD_I), .WDATA_I(WDATA_I),
    .RDATA_O(RDATA_O), .RVALID_O(RVALID_O), .CHARGE_ENABLE_PIN_N_I(CHARGE_ENABLE_PIN_N_I),
    .ALERT_O(ALERT_O), .ALERT_OE_O(ALERT_OE_O), .CHARGER_ON_O(CHARGER_ON_O),
    .CHARGE_CURRENT_CODE_O(CHARGE_CURRENT_CODE_O), .INPUT_LIMIT_CODE_O(INPUT_LIMIT_CODE_O),
    .VOLTAGE_TARGET_O(VOLTAGE_TARGET_O), .BATTERY_TO_SYSTEM_O(BATTERY_TO_SYSTEM_O),
    .OC_PROTECT_O(OC_PROTECT_O), .OC_RATIO_O(OC_RATIO_O));

// >>> test/chgrb_host_model.sv
// Host side model: word writes and reads as one-cycle strobes.
// Assumes tasks are called from the bench, off or on the clock edge.
`timescale 1ns/1ns
module chgrb_host_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] rdata_i,
    input  wire logic        rvalid_i,
    output logic             wr_stb_o,
    output logic             rd_stb_o,
    output logic      [7:0]  cmd_o,
    output logic      [15:0] wdata_o
);
    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    initial begin
        wr_stb_o = 1'b0;
        rd_stb_o = 1'b0;
        cmd_o = 8'h00;
        wdata_o = 16'h0000;
    end
    task automatic write_word(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk_i);
        wr_stb_o <= 1'b1;
        cmd_o <= c;
        wdata_o <= d;
        @(posedge clk_i);
        wr_stb_o <= 1'b0;
        wdata_o <= ~d; // Stale data inverted so no value lingers
    endtask
    task automatic read_word(input logic [7:0] c, output logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        rd_stb_o <= 1'b1;
        cmd_o <= c;
        @(posedge clk_i);
        rd_stb_o <= 1'b0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rvalid_i !== 1'b1 && n < 8);
        d = rdata_i;
    endtask
endmodule

// >>> test/test_chgrb_bank.sv
// Bench: register bank driven through the host model, self-checking.
// Assumes a 10 MHz clock and the fixed 8 ms deglitch of the design.
`timescale 1ns/1ns
module test_chgrb_bank;
    typedef struct packed {
        logic [7:0] c; logic [15:0] w; logic [15:0] r; logic o; logic [7:0] k; logic [8:0] v;
    } chgrb_row_t;
    logic        clk = 1'b0, rst = 1'b1, pin_n = 1'b0, adp = 1'b0, rail = 1'b0;
    logic        vl = 1'b1, dep = 1'b0;
    logic        wr, rd, rv, alert, alert_oe, on, mon, b2s, f5, ocp;
    logic [7:0]  cmd;
    logic [15:0] wd, rdat, got;
    logic [6:0]  icc, ilc;
    logic [8:0]  vt;
    logic [1:0]  ocr;
    logic [2:0]  dsel;
    int          n_mismatch = 0, n_tests = 0, cyc = 0;
    // Target 1FF means the target is not checked
    chgrb_row_t rows [21] = '{
        '{8'h12,16'h0000,16'h0000,1'b0,8'h00,9'h1FF}, '{8'h14,16'h3FFF,16'h3F80,1'b0,8'h00,9'h1FF},
        '{8'h3F,16'h0080,16'h0080,1'b0,8'h00,9'h1FF}, '{8'h15,16'h2EE0,16'h2EE0,1'b1,8'h00,9'h000},
        '{8'h15,16'h32C9,16'h32C8,1'b1,8'h00,9'h035}, '{8'h15,16'h2328,16'h2328,1'b1,8'h00,9'h100},
        '{8'h15,16'h3E80,16'h3E80,1'b1,8'h00,9'h080}, '{8'h15,16'h4275,16'h4274,1'b1,8'h00,9'h0A8},
        '{8'h15,16'hFFFF,16'h7FFE,1'b1,8'h00,9'h0FF}, '{8'h15,16'h2710,16'h2710,1'b0,8'h00,9'h1FF},
        '{8'h15,16'h3A98,16'h3A98,1'b0,8'h00,9'h1FF}, '{8'h15,16'h3E80,16'h3E80,1'b1,8'h00,9'h080},
        '{8'h12,16'h0FF8,16'h0000,1'b1,8'hFF,9'h1FF}, '{8'h12,16'h0180,16'h0000,1'b1,8'h00,9'h1FF},
        '{8'h12,16'h0001,16'h0000,1'b0,8'h00,9'h1FF}, '{8'h12,16'h0000,16'h0000,1'b1,8'h00,9'h1FF},
        '{8'h14,16'hC07F,16'h3F80,1'b1,8'h00,9'h1FF}, '{8'h14,16'h4000,16'h3F80,1'b1,8'h00,9'h1FF},
        '{8'h14,16'h2000,16'h2000,1'b1,8'h00,9'h1FF}, '{8'h3F,16'h0000,16'h0000,1'b0,8'h00,9'h1FF},
        '{8'h3F,16'h3F80,16'h3F80,1'b1,8'h00,9'h1FF}};
    initial begin
        forever #50 clk = ~clk;
    end
    chgrb_host_model host (.clk_i(clk), .rdata_i(rdat), .rvalid_i(rv), .wr_stb_o(wr),
        .rd_stb_o(rd), .cmd_o(cmd), .wdata_o(wd));
    chgrb_bank dut (.CORE_CLK_I(clk), .RST_I(rst), .WR_STB_I(wr), .RD_STB_I(rd), .CMD_I(cmd),
        .WDATA_I(wd), .RDATA_O(rdat), .RVALID_O(rv), .CHARGE_ENABLE_PIN_N_I(pin_n),
        .ADAPTER_PRESENT_I(adp), .RAIL_READY_I(rail), .VLOOP_ACTIVE_I(vl),
        .BAT_DEPLETED_I(dep), .ALERT_O(alert), .ALERT_OE_O(alert_oe), .CHARGER_ON_O(on),
        .CHARGE_CURRENT_CODE_O(icc), .INPUT_LIMIT_CODE_O(ilc), .VOLTAGE_TARGET_O(vt),
        .MONITOR_SELECT_O(mon), .BATTERY_TO_SYSTEM_O(b2s), .FREQ_500K_O(f5),
        .OC_PROTECT_O(ocp), .OC_RATIO_O(ocr), .DEPLETED_SELECT_O(dsel));
    // ------------------------------------------------------------
    // Compare and verdict
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Ceiling covers the one 8 ms deglitch wait plus margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        host.read_word(8'h13, got);
        chk("status idle", 16'(got[2:0]), 16'h0007);
        foreach (rows[i]) begin
            host.write_word(rows[i].c, rows[i].w);
            settle(6);
            chk("charger on", 16'(rows[i].o), 16'(on));
            chk("ctrl outputs", 16'(rows[i].k), 16'({mon, f5, ocp, ocr, dsel}));
            if (rows[i].v !== 9'h1FF) chk("voltage target", 16'(rows[i].v), 16'(vt));
            host.read_word(rows[i].c, got);
            chk("read back", rows[i].r, got);
        end
        chk("current codes", {2'b00, icc, ilc}, 16'h207F);
        pin_n <= 1'b1;
        settle(8);
        chk("pin off", 16'(on), 16'h0000);
        pin_n <= 1'b0;
        settle(8);
        chk("pin on", 16'(on), 16'h0001);
        host.read_word(8'h13, got);
        chk("loop active", 16'(got[2:1]), 16'h0000);
        host.write_word(8'h15, 16'h2710);
        settle(8);
        chk("alert set", 16'(alert_oe), 16'h0001);
        host.read_word(8'h13, got);
        chk("range flag", 16'(got[12]), 16'h0001);
        settle(3);
        chk("alert clear", 16'(alert_oe), 16'h0000);
        host.write_word(8'h15, 16'h3E80);
        host.read_word(8'h20, got);
        chk("unmapped read", got, 16'h0000);
        host.write_word(8'h12, 16'h0004);
        settle(6);
        chk("soft reset", {1'b0, icc, ilc, on}, 16'h0000);
        host.read_word(8'h15, got);
        chk("soft reset volt", got, 16'h0000);
        adp <= 1'b1;
        rail <= 1'b1;
        dep <= 1'b1;
        settle(100);
        host.read_word(8'h13, got);
        chk("deglitch hold", 16'(got[0]), 16'h0001);
        settle(80100);
        host.read_word(8'h13, got);
        chk("ready status", 16'({got[11], got[7:6], got[0]}), 16'h000C);
        print_verdict();
    end
endmodule
